// File: design/ct8_timer.sv
// The address map and register access over APB were decided locally.
`timescale 1ns/1ns
module ct8_timer (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external count and capture input
  input wire logic count_input_pin,
  // interrupts
  output logic timer_irq,
  output logic irq
);

  logic [7:0] timer_control_reg_q;
  logic input_invert_q;
  logic [7:0] cnt_q;
  logic [7:0] compare_capture_a_q;
  logic [7:0] capture_b_q;
  logic armed_q;
  logic [1:0] sts_q;
  logic [1:0] msk_q;
  logic [ct8_pkg::PRE_W-1:0] pre_q;
  logic [31:0] prdata_q;

  ct8_pkg::ct8_mode_t mode;
  logic start;
  logic auto_capture_en;
  logic divider_stage_sel;
  logic [2:0] source_clock_sel;
  logic tick;
  logic cnt_edge;
  logic opp_edge;
  logic acc;
  logic wr;
  logic rd;
  logic rd_a;
  logic rd_sts;
  logic match_tm;
  logic match_ev;
  logic cap_a_ev;
  logic cap_b_ev;
  logic ovf_ev;
  logic hit_ev;
  logic [7:0] cnt_inc;

  ct8_pin_if pif ();

  ct8_pin_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin(count_input_pin),
    .pif(pif.sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decoding helpers

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    return reg_hit(addr, ct8_pkg::OFF_CTRL) || reg_hit(addr, ct8_pkg::OFF_INSEL) ||
      reg_hit(addr, ct8_pkg::OFF_A) || reg_hit(addr, ct8_pkg::OFF_B) ||
      reg_hit(addr, ct8_pkg::OFF_CNT) || reg_hit(addr, ct8_pkg::OFF_STS) ||
      reg_hit(addr, ct8_pkg::OFF_MSK);
  endfunction

  // one tick every 2**e clocks; code 111 gives none
  function automatic logic tick_hit(input logic [ct8_pkg::PRE_W-1:0] pre,
                                    input logic [2:0] code, input logic dv);
    logic [3:0] e;
    logic [ct8_pkg::PRE_W-1:0] m;
    e = 4'(ct8_pkg::DIV_EXP_CODE0 - int'(code));
    if (dv && code <= ct8_pkg::CSEL_SLOW_LAST) begin
      e = 4'(e + 4'h1);
    end
    m = ct8_pkg::PRE_W'((32'h1 << e) - 32'h1);
    return (code != ct8_pkg::CSEL_NONE) && ((pre & m) == m);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // control fields and strobes

  assign mode = ct8_pkg::ct8_mode_t'(timer_control_reg_q[ct8_pkg::CTRL_MODE_LSB +: 2]);
  assign start = timer_control_reg_q[ct8_pkg::CTRL_START];
  assign auto_capture_en = timer_control_reg_q[ct8_pkg::CTRL_AUTO_CAPTURE_EN];
  assign divider_stage_sel = timer_control_reg_q[ct8_pkg::CTRL_DV];
  assign source_clock_sel = timer_control_reg_q[ct8_pkg::CTRL_CSEL_LSB +: 3];

  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign rd_a = rd & reg_hit(paddr, ct8_pkg::OFF_A);
  assign rd_sts = rd & reg_hit(paddr, ct8_pkg::OFF_STS);

  assign tick = start & tick_hit(pre_q, source_clock_sel, divider_stage_sel);
  // counting edge and the opposite edge, per invert setting
  assign cnt_edge = input_invert_q ? pif.fall : pif.rise;
  assign opp_edge = input_invert_q ? pif.rise : pif.fall;
  assign cnt_inc = 8'(cnt_q + 8'h01);

  ////////////////////////////////////////////////////////////////////////////
  // events

  assign match_tm = start && mode == ct8_pkg::MODE_TIMER && tick &&
    cnt_inc == compare_capture_a_q;
  assign match_ev = start && mode == ct8_pkg::MODE_EVENT && opp_edge &&
    cnt_q == compare_capture_a_q;
  assign cap_a_ev = start && mode == ct8_pkg::MODE_CAPTURE && armed_q && cnt_edge;
  assign cap_b_ev = start && mode == ct8_pkg::MODE_CAPTURE && armed_q && opp_edge;
  assign ovf_ev = start && mode == ct8_pkg::MODE_CAPTURE && armed_q && tick &&
    cnt_q == ct8_pkg::CNT_MAX && !cap_a_ev;
  assign hit_ev = match_tm | match_ev | cap_a_ev | ovf_ev;
  assign timer_irq = hit_ev;

  ////////////////////////////////////////////////////////////////////////////
  // prescaler, free running while started

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= '0;
    end else if (!start) begin
      pre_q <= '0;
    end else begin
      pre_q <= ct8_pkg::PRE_W'(pre_q + 1'b1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // up counter

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
    end else if (!start || hit_ev) begin
      cnt_q <= 8'h00;
    end else if (mode == ct8_pkg::MODE_EVENT) begin
      if (cnt_edge) begin
        cnt_q <= cnt_inc;
      end
    end else if (tick) begin
      cnt_q <= cnt_inc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data registers A and B

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      compare_capture_a_q <= ct8_pkg::RST_A;
    end else if (cap_a_ev) begin
      compare_capture_a_q <= cnt_q;
    end else if (ovf_ev) begin
      compare_capture_a_q <= ct8_pkg::OVF_LOAD;
    end else if (wr && reg_hit(paddr, ct8_pkg::OFF_A)) begin
      compare_capture_a_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_b_q <= ct8_pkg::RST_B;
    end else if (cap_b_ev) begin
      capture_b_q <= cnt_q;
    end else if (start && auto_capture_en && mode != ct8_pkg::MODE_CAPTURE) begin
      // copied every clock, regardless of where the count step falls
      capture_b_q <= cnt_q;
    end
  end

  // capture stays halted after its interrupt until A is read or start is cleared
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_q <= 1'b1;
    end else if (!start) begin
      armed_q <= 1'b1;
    end else if (cap_a_ev || ovf_ev) begin
      armed_q <= 1'b0;
    end else if (rd_a) begin
      armed_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_control_reg_q <= ct8_pkg::RST_CTRL;
      input_invert_q <= 1'b0;
      msk_q <= ct8_pkg::RST_MSK;
    end else if (wr) begin
      if (reg_hit(paddr, ct8_pkg::OFF_CTRL)) begin
        timer_control_reg_q <= pwdata[7:0];
      end
      if (reg_hit(paddr, ct8_pkg::OFF_INSEL)) begin
        input_invert_q <= pwdata[ct8_pkg::INSEL_INV];
      end
      if (reg_hit(paddr, ct8_pkg::OFF_MSK)) begin
        msk_q <= pwdata[1:0];
      end
    end
  end

  // sticky status; a read clears only what it returned, a new event wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sts_q <= 2'h0;
    end else begin
      sts_q[ct8_pkg::STS_MATCH] <= (sts_q[ct8_pkg::STS_MATCH] &
        ~(rd_sts & prdata_q[ct8_pkg::STS_MATCH])) | match_tm | match_ev | cap_a_ev;
      sts_q[ct8_pkg::STS_OVF] <= (sts_q[ct8_pkg::STS_OVF] &
        ~(rd_sts & prdata_q[ct8_pkg::STS_OVF])) | ovf_ev;
    end
  end

  assign irq = |(sts_q & msk_q);

  ////////////////////////////////////////////////////////////////////////////
  // apb read data, sampled in the setup cycle

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0;
    end else if (psel && !penable) begin
      prdata_q <= 32'h0;
      if (reg_hit(paddr, ct8_pkg::OFF_CTRL)) begin
        prdata_q[7:0] <= timer_control_reg_q;
      end
      if (reg_hit(paddr, ct8_pkg::OFF_INSEL)) begin
        prdata_q[ct8_pkg::INSEL_INV] <= input_invert_q;
      end
      if (reg_hit(paddr, ct8_pkg::OFF_A)) begin
        prdata_q[7:0] <= compare_capture_a_q;
      end
      if (reg_hit(paddr, ct8_pkg::OFF_B)) begin
        prdata_q[7:0] <= capture_b_q;
      end
      if (reg_hit(paddr, ct8_pkg::OFF_CNT)) begin
        prdata_q[7:0] <= cnt_q;
      end
      if (reg_hit(paddr, ct8_pkg::OFF_STS)) begin
        prdata_q[1:0] <= sts_q;
      end
      if (reg_hit(paddr, ct8_pkg::OFF_MSK)) begin
        prdata_q[1:0] <= msk_q;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = acc;
  assign pslverr = acc & ~mapped(paddr);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  tm_match_clear_a: assert property (match_tm |=> cnt_q == 8'h00 && sts_q[0])
    else $error("timer match did not clear the counter");
  auto_capture_en_copy_a: assert property ((start && auto_capture_en && mode != ct8_pkg::MODE_CAPTURE)
    |=> capture_b_q == $past(cnt_q))
    else $error("auto-capture did not copy the count");
  tick_gap_a: assert property (tick |=> !tick [*8])
    else $error("source ticks too close together");
  ev_count_a: assert property ((start && mode == ct8_pkg::MODE_EVENT && cnt_edge && !match_ev)
    |=> cnt_q == 8'($past(cnt_q) + 8'h01))
    else $error("event edge not counted");
  ev_match_edge_a: assert property ((mode == ct8_pkg::MODE_EVENT && timer_irq)
    |-> (input_invert_q ? pif.rise : pif.fall))
    else $error("event match outside the opposite edge");
  cap_b_load_a: assert property (cap_b_ev |=> capture_b_q == $past(cnt_q))
    else $error("capture into B wrong");
  cap_a_load_a: assert property (cap_a_ev
    |=> compare_capture_a_q == $past(cnt_q) && cnt_q == 8'h00 && !armed_q)
    else $error("capture into A wrong");
  ovf_load_a: assert property (ovf_ev |=> compare_capture_a_q == 8'hff && sts_q[1])
    else $error("overflow did not load FF");
  cap_halt_a: assert property ((mode == ct8_pkg::MODE_CAPTURE && !armed_q)
    |-> !timer_irq && !cap_b_ev)
    else $error("capture active while halted");
  b_hold_a: assert property ((!cap_b_ev && !(start && auto_capture_en &&
    mode != ct8_pkg::MODE_CAPTURE)) |=> $stable(capture_b_q))
    else $error("B changed without a capture");
  irq_pulse_a: assert property ((timer_irq && mode == ct8_pkg::MODE_CAPTURE)
    |=> !timer_irq)
    else $error("capture interrupt longer than one clock");

  cap_a_c: cover property (cap_a_ev);
  ovf_c: cover property (ovf_ev);
  ev_match_c: cover property (match_ev);
  tm_match_c: cover property (match_tm);

endmodule

// File: shared/ct8_pkg.sv
package ct8_pkg;

  // operating modes held in the control register
  typedef enum logic [1:0] {
    MODE_TIMER,
    MODE_EVENT,
    MODE_CAPTURE,
    MODE_RSVD
  } ct8_mode_t;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_INSEL = 8'h04;
  localparam logic [7:0] OFF_A = 8'h08;
  localparam logic [7:0] OFF_B = 8'h0c;
  localparam logic [7:0] OFF_CNT = 8'h10;
  localparam logic [7:0] OFF_STS = 8'h14;
  localparam logic [7:0] OFF_MSK = 8'h18;

  // control and input select register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_CSEL_LSB = 3;
  localparam int CTRL_AUTO_CAPTURE_EN = 6;
  localparam int CTRL_DV = 7;
  localparam int INSEL_INV = 0;

  // status and mask bits
  localparam int STS_MATCH = 0;
  localparam int STS_OVF = 1;

  // values after reset
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_A = 8'h00;
  localparam logic [7:0] RST_B = 8'hff;
  localparam logic [1:0] RST_MSK = 2'h0;

  // counter limits
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] OVF_LOAD = 8'hff;

  // source clock: code 000 divides the clock by 2**13, each code up to 110 halves it, code 111 gives none
  localparam int DIV_EXP_CODE0 = 13;
  localparam int PRE_W = 15;
  localparam logic [2:0] CSEL_SLOW_LAST = 3'h4;
  localparam logic [2:0] CSEL_NONE = 3'h7;

endpackage

// File: shared/ct8_pin_if.sv
`timescale 1ns/1ns
interface ct8_pin_if;
  logic lvl;
  logic rise;
  logic fall;

  modport sync (
    output lvl,
    output rise,
    output fall
  );

  modport core (
    input lvl,
    input rise,
    input fall
  );
endinterface

// File: design/ct8_pin_sync.sv
`timescale 1ns/1ns
module ct8_pin_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // raw pin
  input wire logic pin,
  // filtered level and edges
  ct8_pin_if.sync pif
);

  logic [2:0] sh_q;
  logic [2:0] vld_q;
  logic lvl_vld_q;
  logic lvl_q;
  logic rise_q;
  logic fall_q;
  logic agree;

  ////////////////////////////////////////////////////////////////////////////
  // three-stage synchroniser, change accepted once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_q <= 3'h0;
      vld_q <= 3'h0;
    end else begin
      sh_q <= {sh_q[1:0], pin};
      vld_q <= {vld_q[1:0], 1'b1};
    end
  end

  assign agree = (sh_q[1] == sh_q[2]);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_q <= 1'b0;
      lvl_vld_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      // no edge until the level holds a real sample, a pin idling high is no rise
      lvl_vld_q <= vld_q[2];
      rise_q <= lvl_vld_q & agree & sh_q[2] & ~lvl_q;
      fall_q <= lvl_vld_q & agree & ~sh_q[2] & lvl_q;
      if (agree) begin
        lvl_q <= sh_q[2];
      end
    end
  end

  assign pif.lvl = lvl_q;
  assign pif.rise = rise_q;
  assign pif.fall = fall_q;

endmodule

// File: tb/ct8_pulse_src.sv
`timescale 1ns/1ns
module ct8_pulse_src #(
  parameter int MIN_HOLD = 8
) (
  // clock
  input wire logic clk,
  // pin toward the timer
  output logic pin
);
  initial pin = 1'b0;

  // new level just after an edge, then held; a too short hold is stretched
  task automatic drive(input logic lvl, input int hold);
    @(posedge clk);
    pin <= lvl;
    repeat ((hold < MIN_HOLD) ? MIN_HOLD : hold) @(posedge clk);
  endtask
endmodule

// File: tb/tb_ct8_timer.sv
`timescale 1ns/1ns
module tb_ct8_timer;
  logic clk;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pin;
  logic timer_irq;
  logic irq;
  logic [31:0] rd;
  logic [31:0] exp_b;
  logic err_seen;
  int error_cnt = 0;
  int num_checks = 0;
  int pulses = 0;
  int p0;

  ct8_timer u_ct8_timer (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_input_pin(pin), .timer_irq(timer_irq), .irq(irq));
  ct8_pulse_src u_ct8_pulse_src (.clk(clk), .pin(pin));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // clocks with the request high, so a stretched pulse counts twice
  always @(posedge clk) begin
    if (timer_irq === 1'b1)
      pulses <= pulses + 1;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      check("pready", 32'h0, 32'h1);
      give_verdict();
    end
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    check(what, rd, exp);
  endtask

  task automatic wait_pulse(input string what, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (timer_irq !== 1'b1 && n < lim);
    if (n >= lim) begin
      check(what, 32'h0, 32'h1);
      give_verdict();
    end
  endtask

  // clocks between two match requests
  task automatic period(input int exp);
    int n;
    wait_pulse("first match", 20000);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (timer_irq !== 1'b1 && n < 20000);
    check("timer period", n, exp);
    if (n >= 20000)
      give_verdict();
  endtask

  task automatic pd(input logic lvl, input int hold);
    u_ct8_pulse_src.drive(lvl, hold);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rst_n = 1'b0;
    exp_b = 32'hff;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    // reset values, unmapped and read-only places
    rd_chk("ctrl", ct8_pkg::OFF_CTRL, 32'h0);
    rd_chk("insel", ct8_pkg::OFF_INSEL, 32'h0);
    rd_chk("a", ct8_pkg::OFF_A, 32'h0);
    rd_chk("b", ct8_pkg::OFF_B, 32'hff);
    rd_chk("count", ct8_pkg::OFF_CNT, 32'h0);
    rd_chk("mask", ct8_pkg::OFF_MSK, 32'h0);
    apb(1'b0, 8'h1c, 8'h00);
    check("unmapped err", {31'h0, err_seen}, 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, ct8_pkg::OFF_B, 8'h12);
    rd_chk("b read only", ct8_pkg::OFF_B, 32'hff);
    apb(1'b1, ct8_pkg::OFF_A, 8'h5a);
    rd_chk("a write", ct8_pkg::OFF_A, 32'h5a);
    // capture mode, source code 6, both polarities
    for (int inv = 0; inv < 2; inv++) begin
      apb(1'b1, ct8_pkg::OFF_CTRL, 8'h00);
      apb(1'b1, ct8_pkg::OFF_INSEL, 8'(inv));
      apb(1'b1, ct8_pkg::OFF_CTRL, 8'h35);
      p0 = pulses;
      pd(inv[0], 443);
      pd(~inv[0], 20);
      check("a edge first irq", pulses - p0, 1);
      rd_chk("b skipped", ct8_pkg::OFF_B, exp_b);
      p0 = pulses;
      pd(inv[0], 20);
      pd(~inv[0], 20);
      rd_chk("b halted", ct8_pkg::OFF_B, exp_b);
      rd_chk("a first", ct8_pkg::OFF_A, 32'h3);
      apb(1'b1, ct8_pkg::OFF_CTRL, 8'h00);
      apb(1'b1, ct8_pkg::OFF_CTRL, 8'h35);
      pd(~inv[0], 315);
      pd(inv[0], 384);
      pd(~inv[0], 20);
      check("capture irqs", pulses - p0, 1);
      rd_chk("b width", ct8_pkg::OFF_B, 32'h2);
      rd_chk("a period", ct8_pkg::OFF_A, 32'h5);
      exp_b = 32'h2;
    end
    // event mode with auto capture, both polarities
    for (int inv = 0; inv < 2; inv++) begin
      apb(1'b1, ct8_pkg::OFF_CTRL, 8'h00);
      apb(1'b1, ct8_pkg::OFF_INSEL, 8'(inv));
      pd(inv[0], 8);
      apb(1'b1, ct8_pkg::OFF_A, 8'h03);
      apb(1'b1, ct8_pkg::OFF_CTRL, 8'h43);
      p0 = pulses;
      repeat (2) begin
        pd(~inv[0], 8);
        pd(inv[0], 8);
      end
      pd(~inv[0], 30);
      check("no match while held", pulses - p0, 0);
      rd_chk("count held", ct8_pkg::OFF_CNT, 32'h3);
      rd_chk("auto capture", ct8_pkg::OFF_B, 32'h3);
      pd(inv[0], 30);
      check("match at return edge", pulses - p0, 1);
      rd_chk("count cleared", ct8_pkg::OFF_CNT, 32'h0);
    end
    // timer mode, status, mask and level interrupt
    apb(1'b1, ct8_pkg::OFF_CTRL, 8'h00);
    apb(1'b1, ct8_pkg::OFF_A, 8'h01);
    apb(1'b1, ct8_pkg::OFF_MSK, 8'h01);
    apb(1'b1, ct8_pkg::OFF_CTRL, 8'h31);
    wait_pulse("timer match", 400);
    @(posedge clk);
    check("irq set", {31'h0, irq}, 32'h1);
    rd_chk("status match", ct8_pkg::OFF_STS, 32'h1);
    @(posedge clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    apb(1'b1, ct8_pkg::OFF_MSK, 8'h00);
    wait_pulse("masked match", 400);
    @(posedge clk);
    check("irq masked", {31'h0, irq}, 32'h0);
    for (int c = 0; c < 7; c++) begin
      apb(1'b1, ct8_pkg::OFF_CTRL, {2'b00, c[2:0], 3'b001});
      period(1 << (13 - c));
    end
    // divider option lengthens codes 0 to 4, code 7 gives no tick
    apb(1'b1, ct8_pkg::OFF_CTRL, 8'ha1);
    period(1 << (13 - 4 + 1));
    apb(1'b1, ct8_pkg::OFF_CTRL, 8'h39);
    p0 = pulses;
    repeat (300) @(posedge clk);
    check("no source clock", pulses - p0, 0);
    // second reset in mid-run, B back to FF
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk("b after reset", ct8_pkg::OFF_B, 32'hff);
    rd_chk("ctrl after reset", ct8_pkg::OFF_CTRL, 32'h0);
    // overflow in capture mode with no edge on the pin
    apb(1'b1, ct8_pkg::OFF_CTRL, 8'h00);
    apb(1'b1, ct8_pkg::OFF_MSK, 8'h02);
    apb(1'b1, ct8_pkg::OFF_CTRL, 8'h35);
    wait_pulse("overflow", 34000);
    @(posedge clk);
    check("irq overflow", {31'h0, irq}, 32'h1);
    apb(1'b0, ct8_pkg::OFF_STS, 8'h00);
    check("status overflow", rd & 32'h2, 32'h2);
    rd_chk("a overflow", ct8_pkg::OFF_A, 32'hff);
    give_verdict();
  end
endmodule
